//--- rtl/tpp_cfg.svh
`ifndef TPP_CFG_SVH
`define TPP_CFG_SVH

// Device registers preset by the network strap
`define TPP_REG_NETA     7'h34
`define TPP_BIT_NETA     2
`define TPP_REG_NETB     7'h38
`define TPP_BIT_NETB0    5
`define TPP_BIT_NETB1    6
`define TPP_REG_NETC     7'h64
`define TPP_BIT_NETC     4

// Device interrupt registers
`define TPP_REG_IRQ_STAT 7'h70
`define TPP_REG_IRQ_MASK 7'h71
`define TPP_REG_IRQ_CFG  7'h72
`define TPP_BIT_IRQ_LOW  0

// Host command registers
`define TPP_H_ADDR       3'h0
`define TPP_H_WDATA      3'h1
`define TPP_H_CMD        3'h2
`define TPP_H_STAT       3'h3
`define TPP_H_RDATA      3'h4
`define TPP_H_STYLE      3'h5
`define TPP_H_RESET      3'h6

// Serial frame
`define TPP_SER_ADDR_END 5'h08
`define TPP_SER_LAST     5'h0F
`define TPP_SER_BITS     5'h10

// Timing
`define TPP_CLK_NS       100
`define TPP_SCLK_HALF_NS 400
`define TPP_SCLK_HALF_CYC (`TPP_SCLK_HALF_NS / `TPP_CLK_NS)
`define TPP_BOOT_STEP_NS 300
`define TPP_BOOT_STEP_CYC ((`TPP_BOOT_STEP_NS + `TPP_CLK_NS - 1) / `TPP_CLK_NS)
`define TPP_BOOT_LEN     128

`endif

//--- rtl/tpp_pkg.sv
package tpp_pkg;

  typedef enum logic [2:0] {
    TPP_STY_MUX  = 3'b000,
    TPP_STY_SEP  = 3'b001,
    TPP_STY_RW   = 3'b010,
    TPP_STY_SER  = 3'b011,
    TPP_STY_BOOT = 3'b100
  } tpp_style_t;

  typedef enum logic [1:0] {
    TPP_D_INIT = 2'b00,
    TPP_D_RUN  = 2'b01,
    TPP_D_BLO  = 2'b10,
    TPP_D_BHI  = 2'b11
  } tpp_dstate_t;

  typedef enum logic [2:0] {
    TPP_H_IDLE = 3'b000,
    TPP_H_ALE  = 3'b001,
    TPP_H_LAT  = 3'b010,
    TPP_H_STB  = 3'b011,
    TPP_H_END  = 3'b100,
    TPP_H_SLO  = 3'b101,
    TPP_H_SHI  = 3'b110
  } tpp_hstate_t;

endpackage : tpp_pkg

//--- rtl/tpp_if.sv
`timescale 1ns/1ps
interface tpp_if;
  logic       host_sel_n;
  logic [6:0] host_addr;
  logic [7:0] host_ad_out;
  logic       host_ad_oe;
  logic       write_strobe_n;
  logic       read_strobe_n;
  logic       ale;
  logic       master_reset_n;
  logic       dev_sel_out;
  logic       dev_sel_oe;
  logic       dev_a0_out;
  logic       dev_a0_oe;
  logic [7:0] dev_ad_out;
  logic       dev_ad_oe;
  logic       ready;
  logic       irq_out;
  logic       port_select_n;
  logic [6:0] addr;
  logic [7:0] ad;

  // Wire levels from the enables
  assign port_select_n = dev_sel_oe ? dev_sel_out : host_sel_n;
  assign addr = {host_addr[6:1], dev_a0_oe ? dev_a0_out : host_addr[0]};
  assign ad = dev_ad_oe ? dev_ad_out : (host_ad_oe ? host_ad_out : 8'hFF);

  modport dev (
    input  port_select_n, addr, ad, write_strobe_n, read_strobe_n, ale, master_reset_n,
    output dev_sel_out, dev_sel_oe, dev_a0_out, dev_a0_oe, dev_ad_out, dev_ad_oe, ready, irq_out
  );

  modport host (
    input  ad, ready, irq_out,
    output host_sel_n, host_addr, host_ad_out, host_ad_oe,
    output write_strobe_n, read_strobe_n, ale, master_reset_n
  );
endinterface : tpp_if

//--- rtl/tpp_ser.sv
`timescale 1ns/1ps
`include "tpp_cfg.svh"
module tpp_ser (
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  // Serial pins
  input  wire logic       enable_in,
  input  wire logic       sel_n_in,
  input  wire logic       sclk_in,
  input  wire logic       sdi_in,
  // Register side
  input  wire logic [7:0] rdata_in,
  output logic            wr_out,
  output logic [6:0]      addr_out,
  output logic [7:0]      wdata_out,
  output logic            sdo_out,
  output logic            sdo_oe_out
);

  typedef struct packed {
    logic        p_sclk;
    logic [4:0]  cnt;
    logic [15:0] sh;
    logic        rw;
    logic [6:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        sdo;
    logic        oe;
    logic [6:0]  osh;
  } tpp_ser_state_t;

  tpp_ser_state_t s;
  tpp_ser_state_t n;
  logic [15:0]    shin;

  assign shin = {s.sh[14:0], sdi_in};

  always_comb
  begin
    n = s;
    n.wr = 1'b0;
    n.p_sclk = sclk_in;
    if (!enable_in || sel_n_in)
    begin
      n.cnt = 5'h00;
      n.oe = 1'b0;
    end
    else
    begin
      // Rising clock edge shifts in
      if (!s.p_sclk && sclk_in && s.cnt < `TPP_SER_BITS)
      begin
        n.sh = shin;
        n.cnt = s.cnt + 5'h01;
        if (s.cnt == `TPP_SER_ADDR_END - 5'h01)
        begin
          n.rw = shin[7];
          n.addr = shin[6:0];
        end
        if (s.cnt == `TPP_SER_LAST && !shin[15])
        begin
          n.wr = 1'b1;
          n.wdata = shin[7:0];
        end
      end
      // Falling clock edge shifts out
      if (s.p_sclk && !sclk_in && s.rw && s.cnt >= `TPP_SER_ADDR_END && s.cnt <= `TPP_SER_LAST)
      begin
        n.oe = 1'b1;
        if (s.cnt == `TPP_SER_ADDR_END)
        begin
          n.sdo = rdata_in[7];
          n.osh = rdata_in[6:0];
        end
        else
        begin
          n.sdo = s.osh[6];
          n.osh = {s.osh[5:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      s <= '0;
    else
      s <= n;
  end

  assign wr_out     = s.wr;
  assign addr_out   = s.addr;
  assign wdata_out  = s.wdata;
  assign sdo_out    = s.sdo;
  assign sdo_oe_out = s.oe;

endmodule : tpp_ser

//--- rtl/tpp_dev.sv
`timescale 1ns/1ps
`include "tpp_cfg.svh"
module tpp_dev #(
  parameter int REG_COUNT = 128,
  parameter int BOOT_LEN  = `TPP_BOOT_LEN
) (
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  // Straps
  input  wire logic [2:0] bus_style_strap_in,
  input  wire logic       network_standard_bit_in,
  // Interrupt events
  input  wire logic [7:0] event_in,
  // Status
  output logic [2:0]      style_out,
  output logic            sonet_mode_out,
  // Host port pins
  tpp_if.dev              pins
);

  if (REG_COUNT != 128)
  begin : g_chk_regs
    $error("REG_COUNT must be 128");
  end
  if (BOOT_LEN < 1 || BOOT_LEN > REG_COUNT)
  begin : g_chk_boot
    $error("BOOT_LEN out of range");
  end

  typedef struct packed {
    tpp_pkg::tpp_dstate_t st;
    tpp_pkg::tpp_style_t  style;
    logic                 p_ale;
    logic [6:0]           alat;
    logic [127:0][7:0]    regs;
    logic                 rdy;
    logic [7:0]           ad_out;
    logic                 ad_oe;
    logic                 sel_n;
    logic                 sel_oe;
    logic                 a0;
    logic                 a0_oe;
    logic [6:0]           bidx;
    logic [3:0]           bcnt;
    logic                 irq;
  } tpp_dev_state_t;

  tpp_dev_state_t s;
  tpp_dev_state_t n;

  logic       sel_act;
  logic       rd_act;
  logic       wr_act;
  logic [6:0] acc_addr;
  logic       ser_wr;
  logic [6:0] ser_addr;
  logic [7:0] ser_wdata;
  logic       ser_sdo;
  logic       ser_oe;
  logic       any_irq;

  function automatic tpp_pkg::tpp_style_t norm_style(input logic [2:0] code);
    tpp_pkg::tpp_style_t r;
    unique case (code)
      3'h0:    r = tpp_pkg::TPP_STY_MUX;
      3'h1:    r = tpp_pkg::TPP_STY_SEP;
      3'h2:    r = tpp_pkg::TPP_STY_RW;
      3'h3:    r = tpp_pkg::TPP_STY_SER;
      3'h4:    r = tpp_pkg::TPP_STY_BOOT;
      default: r = tpp_pkg::TPP_STY_SEP;
    endcase
    return r;
  endfunction : norm_style

  // Register write; status bits clear on a one
  function automatic logic [127:0][7:0] wr_fn(input logic [127:0][7:0] r, input logic [6:0] a,
                                              input logic [7:0] d);
    logic [127:0][7:0] q;
    q = r;
    if (a == `TPP_REG_IRQ_STAT)
      q[a] = r[a] & ~d;
    else
      q[a] = d;
    return q;
  endfunction : wr_fn

  // Access decode per bus style
  assign sel_act  = !pins.port_select_n;
  assign rd_act   = (s.style == tpp_pkg::TPP_STY_RW) ? (!pins.read_strobe_n && pins.write_strobe_n)
                                                     : !pins.read_strobe_n;
  assign wr_act   = (s.style == tpp_pkg::TPP_STY_RW) ? (!pins.read_strobe_n && !pins.write_strobe_n)
                                                     : !pins.write_strobe_n;
  assign acc_addr = (s.style == tpp_pkg::TPP_STY_MUX) ? s.alat : pins.addr;

  tpp_ser u_ser (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .enable_in  (s.st == tpp_pkg::TPP_D_RUN && s.style == tpp_pkg::TPP_STY_SER),
    .sel_n_in   (pins.port_select_n),
    .sclk_in    (pins.ale),
    .sdi_in     (pins.addr[0]),
    .rdata_in   (s.regs[ser_addr]),
    .wr_out     (ser_wr),
    .addr_out   (ser_addr),
    .wdata_out  (ser_wdata),
    .sdo_out    (ser_sdo),
    .sdo_oe_out (ser_oe)
  );

  always_comb
  begin
    n = s;
    n.p_ale = pins.ale;
    any_irq = 1'b0;
    if (!pins.master_reset_n)
    begin
      n = '0;
      n.sel_n = 1'b1;
    end
    else
    begin
      unique case (s.st)
        tpp_pkg::TPP_D_INIT:
        begin
          n.style = norm_style(bus_style_strap_in);
          n.regs[`TPP_REG_NETA][`TPP_BIT_NETA]  = network_standard_bit_in;
          n.regs[`TPP_REG_NETB][`TPP_BIT_NETB0] = network_standard_bit_in;
          n.regs[`TPP_REG_NETB][`TPP_BIT_NETB1] = network_standard_bit_in;
          n.regs[`TPP_REG_NETC][`TPP_BIT_NETC]  = network_standard_bit_in;
          if (n.style == tpp_pkg::TPP_STY_BOOT)
          begin
            n.st = tpp_pkg::TPP_D_BLO;
            n.sel_oe = 1'b1;
            n.sel_n = 1'b0;
            n.a0_oe = 1'b1;
            n.a0 = 1'b0;
          end
          else
            n.st = tpp_pkg::TPP_D_RUN;
        end
        tpp_pkg::TPP_D_RUN:
        begin
          if (s.p_ale && !pins.ale && s.style != tpp_pkg::TPP_STY_SER)
            n.alat = (s.style == tpp_pkg::TPP_STY_MUX) ? pins.ad[6:0] : pins.addr;
          if (s.style == tpp_pkg::TPP_STY_SER)
          begin
            n.ad_out = {7'h00, ser_sdo};
            n.ad_oe = ser_oe && sel_act;
            if (ser_wr)
              n.regs = wr_fn(s.regs, ser_addr, ser_wdata);
          end
          else if (!sel_act || !(rd_act || wr_act))
          begin
            n.rdy = 1'b0;
            n.ad_oe = 1'b0;
          end
          else if (!s.rdy)
          begin
            n.rdy = 1'b1;
            if (rd_act)
            begin
              n.ad_out = s.regs[acc_addr];
              n.ad_oe = 1'b1;
            end
            else
              n.regs = wr_fn(s.regs, acc_addr, pins.ad);
          end
        end
        tpp_pkg::TPP_D_BLO:
        begin
          n.bcnt = s.bcnt + 4'h1;
          if (s.bcnt == 4'(`TPP_BOOT_STEP_CYC - 1))
          begin
            n.regs = wr_fn(s.regs, s.bidx, pins.ad);
            n.bcnt = 4'h0;
            n.a0 = 1'b1;
            n.st = tpp_pkg::TPP_D_BHI;
          end
        end
        tpp_pkg::TPP_D_BHI:
        begin
          n.bcnt = s.bcnt + 4'h1;
          if (s.bcnt == 4'(`TPP_BOOT_STEP_CYC - 1))
          begin
            n.bcnt = 4'h0;
            n.a0 = 1'b0;
            if (s.bidx == 7'(BOOT_LEN - 1))
            begin
              n.st = tpp_pkg::TPP_D_RUN;
              n.sel_oe = 1'b0;
              n.sel_n = 1'b1;
              n.a0_oe = 1'b0;
            end
            else
            begin
              n.bidx = s.bidx + 7'h01;
              n.st = tpp_pkg::TPP_D_BLO;
            end
          end
        end
      endcase
      // Events set status after any clear
      n.regs[`TPP_REG_IRQ_STAT] = n.regs[`TPP_REG_IRQ_STAT] | event_in;
      any_irq = |(n.regs[`TPP_REG_IRQ_STAT] & n.regs[`TPP_REG_IRQ_MASK]);
      n.irq = n.regs[`TPP_REG_IRQ_CFG][`TPP_BIT_IRQ_LOW] ? !any_irq : any_irq;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s <= '0;
      s.sel_n <= 1'b1;
    end
    else
      s <= n;
  end

  // Pin drivers
  assign pins.dev_sel_out = s.sel_n;
  assign pins.dev_sel_oe  = s.sel_oe;
  assign pins.dev_a0_out  = s.a0;
  assign pins.dev_a0_oe   = s.a0_oe;
  assign pins.dev_ad_out  = s.ad_out;
  assign pins.dev_ad_oe   = s.ad_oe;
  assign pins.ready       = s.rdy;
  assign pins.irq_out     = s.irq;

  // Status
  assign style_out      = s.style;
  assign sonet_mode_out = s.regs[`TPP_REG_NETA][`TPP_BIT_NETA];

endmodule : tpp_dev

//--- rtl/tpp_host.sv
`timescale 1ns/1ps
`include "tpp_cfg.svh"
module tpp_host #(
  parameter int SCLK_HALF = `TPP_SCLK_HALF_CYC
) (
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  // Command port
  input  wire logic [2:0] cmd_addr_in,
  input  wire logic [7:0] cmd_wdata_in,
  input  wire logic       cmd_wr_in,
  input  wire logic       cmd_rd_in,
  output logic [7:0]      cmd_rdata_out,
  // Device pins
  tpp_if.host             pins
);

  if (SCLK_HALF < 3 || SCLK_HALF > 15)
  begin : g_chk_half
    $error("SCLK_HALF out of range");
  end

  typedef struct packed {
    tpp_pkg::tpp_hstate_t st;
    logic [6:0]           addr;
    logic [7:0]           wdata;
    logic                 rnw;
    logic [1:0]           style;
    logic                 mrst_n;
    logic [7:0]           rdata;
    logic                 busy;
    logic [7:0]           rq;
    logic                 sel_n;
    logic                 wr_n;
    logic                 rd_n;
    logic                 ale;
    logic [7:0]           ad_out;
    logic                 ad_oe;
    logic [6:0]           a_out;
    logic [3:0]           bitn;
    logic [3:0]           hcnt;
    logic [15:0]          sh;
  } tpp_host_state_t;

  tpp_host_state_t     s;
  tpp_host_state_t     n;
  tpp_pkg::tpp_style_t sty;

  assign sty = tpp_pkg::tpp_style_t'({1'b0, s.style});

  always_comb
  begin
    n = s;
    n.rq = 8'h00;
    if (cmd_rd_in)
    begin
      unique case (cmd_addr_in)
        `TPP_H_ADDR:  n.rq = {1'b0, s.addr};
        `TPP_H_WDATA: n.rq = s.wdata;
        `TPP_H_STAT:  n.rq = {6'h00, pins.irq_out, s.busy};
        `TPP_H_RDATA: n.rq = s.rdata;
        `TPP_H_STYLE: n.rq = {6'h00, s.style};
        `TPP_H_RESET: n.rq = {7'h00, !s.mrst_n};
        default:      n.rq = 8'h00;
      endcase
    end
    if (cmd_wr_in)
    begin
      unique case (cmd_addr_in)
        `TPP_H_ADDR:  n.addr = cmd_wdata_in[6:0];
        `TPP_H_WDATA: n.wdata = cmd_wdata_in;
        `TPP_H_STYLE: n.style = cmd_wdata_in[1:0];
        `TPP_H_RESET: n.mrst_n = !cmd_wdata_in[0];
        `TPP_H_CMD:
        begin
          if (s.st == tpp_pkg::TPP_H_IDLE)
          begin
            n.busy = 1'b1;
            n.rnw = cmd_wdata_in[0];
            n.sel_n = 1'b0;
            n.a_out = s.addr;
            if (sty == tpp_pkg::TPP_STY_SER)
            begin
              n.sh = {cmd_wdata_in[0], s.addr, s.wdata};
              n.a_out[0] = cmd_wdata_in[0];
              n.bitn = 4'h0;
              n.hcnt = 4'h0;
              n.st = tpp_pkg::TPP_H_SLO;
            end
            else
            begin
              n.ad_out = {1'b0, s.addr};
              n.ad_oe = (sty == tpp_pkg::TPP_STY_MUX);
              n.ale = (sty == tpp_pkg::TPP_STY_MUX);
              n.st = tpp_pkg::TPP_H_ALE;
            end
          end
        end
        default:
        begin
        end
      endcase
    end
    unique case (s.st)
      tpp_pkg::TPP_H_IDLE:
      begin
      end
      tpp_pkg::TPP_H_ALE:
      begin
        n.ale = 1'b0;
        n.st = tpp_pkg::TPP_H_LAT;
      end
      tpp_pkg::TPP_H_LAT:
      begin
        n.ad_out = s.wdata;
        n.ad_oe = !s.rnw;
        if (sty == tpp_pkg::TPP_STY_RW)
        begin
          n.rd_n = 1'b0;
          n.wr_n = s.rnw;
        end
        else if (s.rnw)
          n.rd_n = 1'b0;
        else
          n.wr_n = 1'b0;
        n.st = tpp_pkg::TPP_H_STB;
      end
      tpp_pkg::TPP_H_STB:
      begin
        if (pins.ready)
        begin
          if (s.rnw)
            n.rdata = pins.ad;
          n.sel_n = 1'b1;
          n.rd_n = 1'b1;
          n.wr_n = 1'b1;
          n.ad_oe = 1'b0;
          n.st = tpp_pkg::TPP_H_END;
        end
      end
      tpp_pkg::TPP_H_END:
      begin
        if (!pins.ready)
        begin
          n.busy = 1'b0;
          n.st = tpp_pkg::TPP_H_IDLE;
        end
      end
      tpp_pkg::TPP_H_SLO:
      begin
        n.a_out[0] = s.sh[15];
        n.hcnt = s.hcnt + 4'h1;
        if (s.hcnt == 4'(SCLK_HALF - 1))
        begin
          n.hcnt = 4'h0;
          n.ale = 1'b1;
          n.st = tpp_pkg::TPP_H_SHI;
        end
      end
      tpp_pkg::TPP_H_SHI:
      begin
        n.hcnt = s.hcnt + 4'h1;
        if (s.hcnt == 4'(SCLK_HALF - 1))
        begin
          n.hcnt = 4'h0;
          n.ale = 1'b0;
          n.sh = {s.sh[14:0], 1'b0};
          if (s.rnw && s.bitn >= 4'h8)
            n.rdata = {s.rdata[6:0], pins.ad[0]};
          if (s.bitn == 4'hF)
          begin
            n.sel_n = 1'b1;
            n.st = tpp_pkg::TPP_H_END;
          end
          else
          begin
            n.bitn = s.bitn + 4'h1;
            n.st = tpp_pkg::TPP_H_SLO;
          end
        end
      end
      default:
        n.st = tpp_pkg::TPP_H_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s <= '0;
      s.sel_n <= 1'b1;
      s.wr_n <= 1'b1;
      s.rd_n <= 1'b1;
      s.mrst_n <= 1'b1;
    end
    else
      s <= n;
  end

  assign cmd_rdata_out       = s.rq;
  assign pins.host_sel_n     = s.sel_n;
  assign pins.host_addr      = s.a_out;
  assign pins.host_ad_out    = s.ad_out;
  assign pins.host_ad_oe     = s.ad_oe;
  assign pins.write_strobe_n = s.wr_n;
  assign pins.read_strobe_n  = s.rd_n;
  assign pins.ale            = s.ale;
  assign pins.master_reset_n = s.mrst_n;

endmodule : tpp_host

//--- test/tpp_monitor.sv
`timescale 1ns/1ps
module tpp_monitor (
  // Clock and reset
  input  wire logic sys_clk_in,
  input  wire logic rst_n_in,
  // Host side wires
  input  wire logic port_select_n,
  input  wire logic write_strobe_n,
  input  wire logic read_strobe_n,
  input  wire logic ale,
  input  wire logic master_reset_n,
  input  wire logic host_ad_oe,
  // Device side wires
  input  wire logic ready,
  input  wire logic dev_ad_oe,
  input  wire logic dev_sel_oe,
  input  wire logic dev_sel_out,
  input  wire logic dev_a0_oe,
  input  wire logic dev_a0_out
);
  default clocking mon_clk @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // Selected with a strobe active
  sequence s_access;
    !port_select_n && (!read_strobe_n || !write_strobe_n);
  endsequence
  // Select or both strobes let go
  sequence s_released;
    port_select_n || (read_strobe_n && write_strobe_n);
  endsequence

  a_ready_answer: assert property (s_access ##0 !ready |=> ready)
    else $error("ready missing one cycle after strobe");
  a_ready_origin: assert property ($rose(ready) |-> !port_select_n && !$past(port_select_n))
    else $error("ready raised while deselected");
  a_ready_drop: assert property (s_released ##0 ready |=> !ready)
    else $error("ready held after release");
  a_bus_release: assert property (dev_ad_oe |-> !$past(port_select_n))
    else $error("bus driven without select");
  a_bus_no_fight: assert property (dev_ad_oe |-> !host_ad_oe)
    else $error("both ends drive the bus");
  a_boot_pins: assert property (dev_sel_oe |-> dev_a0_oe && !dev_sel_out)
    else $error("boot pins not driven together");
  a_boot_step: assert property (dev_a0_oe && $rose(dev_a0_out) |=> (dev_a0_out || !dev_a0_oe)[*2])
    else $error("boot address step too short");
  a_read_hold: assert property (s_access ##0 (!read_strobe_n && !ready) |=> !read_strobe_n && !port_select_n)
    else $error("read strobe dropped before ready");
  a_write_hold: assert property (s_access ##0 (!write_strobe_n && !ready) |=> !write_strobe_n)
    else $error("write strobe dropped before ready");
  a_sclk_half: assert property ($rose(ale) && !host_ad_oe && !port_select_n |=> ale[*2])
    else $error("serial clock high phase too short");
  a_master_reset: assert property (!master_reset_n |=> !ready && !dev_ad_oe)
    else $error("device active during master reset");
endmodule : tpp_monitor

//--- test/timing_chip_host_port_pins_tb.sv
`timescale 1ns/1ps
`include "tpp_cfg.svh"
module timing_chip_host_port_pins_tb;
  logic       sys_clk_in = 1'b0;
  logic       rst_n_in   = 1'b0;
  logic [2:0] strap      = 3'h0;
  logic       net_bit    = 1'b0;
  logic [7:0] events     = 8'h00;
  logic [2:0] c_addr     = 3'h0;
  logic [7:0] c_wdata    = 8'h00;
  logic       c_wr       = 1'b0;
  logic       c_rd       = 1'b0;
  logic [7:0] c_rdata;
  logic [2:0] style;
  logic       sonet;
  logic [7:0] rv;
  int         error_cnt;
  int         samples_checked;
  int         cycles;

  tpp_if link ();
  tpp_dev #(.BOOT_LEN(2)) tpp_dev_inst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .bus_style_strap_in(strap), .network_standard_bit_in(net_bit), .event_in(events),
    .style_out(style), .sonet_mode_out(sonet), .pins(link.dev));
  tpp_host #(.SCLK_HALF(3)) tpp_host_inst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .cmd_addr_in(c_addr), .cmd_wdata_in(c_wdata), .cmd_wr_in(c_wr), .cmd_rd_in(c_rd),
    .cmd_rdata_out(c_rdata), .pins(link.host));
  tpp_monitor tpp_monitor_inst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .port_select_n(link.port_select_n), .write_strobe_n(link.write_strobe_n),
    .read_strobe_n(link.read_strobe_n), .ale(link.ale), .master_reset_n(link.master_reset_n),
    .host_ad_oe(link.host_ad_oe), .ready(link.ready), .dev_ad_oe(link.dev_ad_oe),
    .dev_sel_oe(link.dev_sel_oe), .dev_sel_out(link.dev_sel_out),
    .dev_a0_oe(link.dev_a0_oe), .dev_a0_out(link.dev_a0_out));

  always #50 sys_clk_in = ~sys_clk_in;

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  // Hang guard
  always @(posedge sys_clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      error_cnt++;
      close_out();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cmd_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    c_addr  <= a;
    c_wdata <= d;
    c_wr    <= 1'b1;
    @(posedge sys_clk_in);
    c_wr <= 1'b0;
  endtask : cmd_write

  task automatic cmd_read(input logic [2:0] a);
    @(posedge sys_clk_in);
    c_addr <= a;
    c_rd   <= 1'b1;
    @(posedge sys_clk_in);
    c_rd <= 1'b0;
    #1 rv = c_rdata;
  endtask : cmd_read

  // One device access through the host; read data left in rv
  task automatic dev_access(input logic rd, input logic [6:0] a, input logic [7:0] wd);
    int i;
    cmd_write(`TPP_H_ADDR, {1'b0, a});
    cmd_write(`TPP_H_WDATA, wd);
    cmd_write(`TPP_H_CMD, {7'h00, rd});
    rv = 8'h01;
    for (i = 0; i < 200 && rv[0] !== 1'b0; i++)
      cmd_read(`TPP_H_STAT);
    check("host busy", {7'h00, rv[0]}, 8'h00);
    if (rd)
      cmd_read(`TPP_H_RDATA);
  endtask : dev_access

  // Straps changed, then a master reset pulse
  task automatic set_style(input logic [2:0] st, input logic net);
    @(posedge sys_clk_in);
    strap   <= st;
    net_bit <= net;
    cmd_write(`TPP_H_STYLE, {6'h00, st[1:0]});
    cmd_write(`TPP_H_RESET, 8'h01);
    cmd_write(`TPP_H_RESET, 8'h00);
    repeat (4) @(posedge sys_clk_in);
    check("style", {5'h00, style}, {5'h00, st});
  endtask : set_style

  task automatic t_presets(input logic net);
    set_style(3'h0, net);
    check("network mode", {7'h00, sonet}, {7'h00, net});
    dev_access(1'b1, `TPP_REG_NETA, 8'h00);
    check("preset 34h", rv, {5'h00, net, 2'h0});
    dev_access(1'b1, `TPP_REG_NETB, 8'h00);
    check("preset 38h", rv, {1'b0, net, net, 5'h00});
    dev_access(1'b1, `TPP_REG_NETC, 8'h00);
    check("preset 64h", rv, {3'h0, net, 4'h0});
    dev_access(1'b0, `TPP_REG_NETA, {5'h00, !net, 2'h0});
    dev_access(1'b1, `TPP_REG_NETA, 8'h00);
    check("rewritten 34h", rv, {5'h00, !net, 2'h0});
    check("network mode rewritten", {7'h00, sonet}, {7'h00, !net});
  endtask : t_presets

  // Each parallel style, back to back addresses; serial style last
  task automatic t_styles();
    logic [2:0] st;
    for (int s = 0; s < 4; s++)
    begin
      st = s[2:0];
      set_style(st, 1'b0);
      dev_access(1'b1, `TPP_REG_NETB, 8'h00);
      check("38h after master reset", rv, 8'h00);
      dev_access(1'b0, `TPP_REG_NETB, {5'h14, st});
      dev_access(1'b0, 7'h10, {5'h0B, st});
      dev_access(1'b1, `TPP_REG_NETB, 8'h00);
      check("38h readback", rv, {5'h14, st});
      dev_access(1'b1, 7'h10, 8'h00);
      check("10h readback", rv, {5'h0B, st});
    end
  endtask : t_styles

  task automatic pulse(input logic [7:0] e, input logic exp);
    @(posedge sys_clk_in);
    events <= e;
    @(posedge sys_clk_in);
    events <= 8'h00;
    repeat (3) @(posedge sys_clk_in);
    check("irq pin", {7'h00, link.irq_out}, {7'h00, exp});
  endtask : pulse

  task automatic t_irq();
    set_style(3'h1, 1'b0);
    dev_access(1'b0, `TPP_REG_IRQ_CFG, 8'h00);
    dev_access(1'b0, `TPP_REG_IRQ_MASK, 8'h04);
    pulse(8'h01, 1'b0);
    pulse(8'h04, 1'b1);
    cmd_read(`TPP_H_STAT);
    check("host irq status bit", rv & 8'h02, 8'h02);
    dev_access(1'b1, `TPP_REG_IRQ_STAT, 8'h00);
    check("irq status", rv, 8'h05);
    dev_access(1'b0, `TPP_REG_IRQ_STAT, 8'h05);
    check("irq cleared", {7'h00, link.irq_out}, 8'h00);
    dev_access(1'b0, `TPP_REG_IRQ_CFG, 8'h01);
    check("irq idle low polarity", {7'h00, link.irq_out}, 8'h01);
  endtask : t_irq

  task automatic t_boot();
    int i;
    set_style(3'h4, 1'b0);
    check("boot select drive", {7'h00, link.dev_sel_oe}, 8'h01);
    for (i = 0; i < 60 && link.dev_sel_oe !== 1'b0; i++)
      @(posedge sys_clk_in);
    check("boot pins released", {6'h00, link.dev_sel_oe, link.dev_a0_oe}, 8'h00);
    check("select idle", {7'h00, link.port_select_n}, 8'h01);
    dev_access(1'b1, 7'h00, 8'h00);
    check("boot byte", rv, 8'hFF);
  endtask : t_boot

  initial
  begin
    repeat (20) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    t_presets(1'b0);
    t_presets(1'b1);
    t_styles();
    t_irq();
    t_boot();
    close_out();
  end
endmodule : timing_chip_host_port_pins_tb
